// file: uart_rx_qualifier.sv
// Serial receiver with framing-error and multiprocessor frame qualification.
// Assumes rxd_i is an asynchronous pin; registers on classic Wishbone, 32-bit.
`timescale 1ns/10ps
`default_nettype none
module uart_rx_qualifier (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Serial line
  input  wire logic        rxd_i,
  // Status
  output logic             rx_done_flag_o
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_NINTH = 5'b01000,
    ST_STOP  = 5'b10000
  } rx_state_t;

  // ==========================================================
  // Registers
  logic [7:0]  serial_control_reg;
  logic        frame_error_flag_reg;
  logic        baud_double_reg;
  logic        frame_err_access_sel_reg;
  logic [7:0]  rx_data_reg;
  logic [7:0]  timer1_reload_high_reg;
  logic [15:0] timer3_reload_reg;
  logic [7:0]  clock_control_reg;
  logic [15:0] slave_addr_reg;
  logic [2:0]  sync_reg;
  logic        line_reg;
  logic        line_prev_reg;
  rx_state_t   state_reg;
  logic [3:0]  os_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic        ninth_reg;
  logic        tick;

  // ==========================================================
  // Decode
  logic                    req;
  logic                    wr;
  logic                    hit_sc;
  logic                    hit_pc;
  logic                    hit_t1;
  logic                    hit_t3;
  logic                    hit_ck;
  logic                    hit_sa;
  logic                    hit_rd;
  logic [31:0]             rdata;
  logic [1:0]              mode_w;
  logic                    async_mode;
  logic                    mp_en;
  logic                    centre;
  logic                    frame_end;
  uart_qual_pkg::rx_frame_t frame;
  logic                    qual_bit;
  logic                    addr_match;
  logic                    accept;
  logic                    frame_err_event;
  logic                    frame_err_write;
  logic                    start_edge;

  assign req    = cyc_i && stb_i && !ack_o;
  assign wr     = req && we_i && sel_i[0];
  assign hit_sc = (adr_i == uart_qual_pkg::ADDR_SERIAL_CTRL);
  assign hit_pc = (adr_i == uart_qual_pkg::ADDR_POWER_CTRL);
  assign hit_rd = (adr_i == uart_qual_pkg::ADDR_RX_DATA);
  assign hit_t1 = (adr_i == uart_qual_pkg::ADDR_T1_RELOAD);
  assign hit_t3 = (adr_i == uart_qual_pkg::ADDR_T3_RELOAD);
  assign hit_ck = (adr_i == uart_qual_pkg::ADDR_CLOCK_CTRL);
  assign hit_sa = (adr_i == uart_qual_pkg::ADDR_SLAVE_ADDR);

  assign mode_w     = serial_control_reg[uart_qual_pkg::SC_MODE_HIGH -: 2];
  assign async_mode = (mode_w != 2'h0);
  assign mp_en      = serial_control_reg[uart_qual_pkg::SC_MP_EN] && async_mode;
  assign centre     = tick && (os_reg == uart_qual_pkg::SAMPLE_CENTRE);
  assign frame_end  = (state_reg == ST_STOP) && centre;

  assign frame.data    = shift_reg;
  assign frame.ninth   = ninth_reg;
  assign frame.stop_ok = line_reg;
  // Mode 1: stop bit stands in for the ninth bit
  assign qual_bit   = (mode_w == 2'h1) ? frame.stop_ok : frame.ninth;
  // Given/broadcast matching: mask in high byte, own address in low byte
  assign addr_match = ((frame.data & slave_addr_reg[15:8]) ==
                       (slave_addr_reg[7:0] & slave_addr_reg[15:8])) ||
                      ((frame.data | ~(slave_addr_reg[7:0] | slave_addr_reg[15:8]))
                       == 8'hff);
  assign accept     = frame_end && !serial_control_reg[uart_qual_pkg::SC_RX_DONE] &&
                      (!mp_en || (qual_bit && addr_match));
  assign frame_err_event = frame_end && !frame.stop_ok;
  assign frame_err_write = wr && hit_sc && frame_err_access_sel_reg;
  // Only a fresh falling edge starts a frame; a line still low after a bad stop must not
  assign start_edge      = line_prev_reg && !line_reg;

  assign rdata = hit_sc ? {24'h0, (frame_err_access_sel_reg ? frame_error_flag_reg
                                   : serial_control_reg[7]), serial_control_reg[6:0]} :
                 hit_pc ? {24'h0, baud_double_reg, frame_err_access_sel_reg, 6'h00} :
                 hit_rd ? {24'h0, rx_data_reg} :
                 hit_t1 ? {24'h0, timer1_reload_high_reg} :
                 hit_t3 ? {16'h0, timer3_reload_reg} :
                 hit_ck ? {24'h0, clock_control_reg} :
                 hit_sa ? {16'h0, slave_addr_reg} : 32'h0000_0000;

  uart_baud_gen u_baud (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .mode_i                (mode_w),
    .baud_double_i         (baud_double_reg),
    .timer1_clock_select_i (clock_control_reg[uart_qual_pkg::CK_T1_CLKSEL]),
    .use_timer3_i          (clock_control_reg[uart_qual_pkg::CK_BAUD_SRC]),
    .timer1_reload_high_i  (timer1_reload_high_reg),
    .timer3_reload_i       (timer3_reload_reg),
    .tick_o                (tick)
  );

  // ==========================================================
  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o                    <= 1'b0;
      dat_o                    <= 32'h0000_0000;
      serial_control_reg       <= uart_qual_pkg::SERIAL_CTRL_RESET;
      baud_double_reg          <= 1'b0;
      frame_err_access_sel_reg <= 1'b0;
      timer1_reload_high_reg   <= 8'h00;
      timer3_reload_reg        <= 16'h0000;
      clock_control_reg        <= 8'h00;
      slave_addr_reg           <= 16'h0000;
    end else begin
      ack_o <= req;
      if (req) dat_o <= rdata;
      if (wr && hit_sc) begin
        if (!frame_err_access_sel_reg) serial_control_reg[7] <= dat_i[7];
        serial_control_reg[6:1] <= dat_i[6:1];
      end
      if (accept) serial_control_reg[uart_qual_pkg::SC_RX_NINTH] <= qual_bit;
      // Set beats a same-cycle clear
      if (accept) serial_control_reg[0] <= 1'b1;
      else if (wr && hit_sc) serial_control_reg[0] <= dat_i[0];
      if (wr && hit_pc) begin
        baud_double_reg          <= dat_i[uart_qual_pkg::PC_BAUD_DBL];
        frame_err_access_sel_reg <= dat_i[uart_qual_pkg::PC_ERR_SEL];
      end
      if (wr && hit_t1) timer1_reload_high_reg <= dat_i[7:0];
      if (wr && hit_t3 && sel_i[1]) timer3_reload_reg[15:8] <= dat_i[15:8];
      if (wr && hit_t3) timer3_reload_reg[7:0] <= dat_i[7:0];
      if (wr && hit_ck) clock_control_reg <= dat_i[7:0];
      if (wr && hit_sa && sel_i[1]) slave_addr_reg[15:8] <= dat_i[15:8];
      if (wr && hit_sa) slave_addr_reg[7:0] <= dat_i[7:0];
    end
  end

  // Sticky error: only a software write lowers it
  always_ff @(posedge clk_i) begin
    if (rst_i) frame_error_flag_reg <= 1'b0;
    else if (frame_err_event && async_mode) frame_error_flag_reg <= 1'b1;
    else if (frame_err_write) frame_error_flag_reg <= dat_i[7];
  end

  // ==========================================================
  // Receiver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_reg       <= 3'h7;
      line_reg       <= 1'b1;
      line_prev_reg  <= 1'b1;
      state_reg      <= ST_IDLE;
      os_reg         <= 4'h0;
      bit_reg        <= 3'h0;
      shift_reg      <= 8'h00;
      ninth_reg      <= 1'b0;
      rx_data_reg    <= 8'h00;
      rx_done_flag_o <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], rxd_i};
      if (sync_reg[1] == sync_reg[2]) line_reg <= sync_reg[2];
      line_prev_reg <= line_reg;
      rx_done_flag_o <= serial_control_reg[uart_qual_pkg::SC_RX_DONE] | accept;
      if (accept) rx_data_reg <= frame.data;
      if (tick) os_reg <= os_reg + 4'h1;
      case (state_reg)
        ST_IDLE: begin
          os_reg <= 4'h0;
          if (start_edge && async_mode && serial_control_reg[uart_qual_pkg::SC_RX_EN])
            state_reg <= ST_START;
        end
        ST_START: begin
          if (centre) state_reg <= line_reg ? ST_IDLE : ST_DATA;
        end
        ST_DATA: begin
          if (centre) begin
            shift_reg <= {line_reg, shift_reg[7:1]};
            bit_reg   <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) state_reg <= mode_w[1] ? ST_NINTH : ST_STOP;
          end
        end
        ST_NINTH: begin
          if (centre) begin
            ninth_reg <= line_reg;
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (centre) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  AST_FRAME_ERR_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_error_flag_reg && !frame_err_write |=> frame_error_flag_reg)
    else $error("frame error flag dropped without write");
  AST_FRAME_ERR_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_err_event && async_mode |=> frame_error_flag_reg)
    else $error("bad stop bit did not set frame error");
  AST_MP_NINTH: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && mp_en && mode_w[1] && !frame.ninth |=> $stable(rx_data_reg))
    else $error("ninth-bit-zero frame accepted under multiproc");
  AST_MODE1_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && mp_en && mode_w == 2'h1 && !frame.stop_ok |-> !accept)
    else $error("mode 1 frame accepted without stop");
  // Done shows in the register and on the registered pin in the same cycle; the check samples the pin a cycle later
  sequence s_done_raised;
    serial_control_reg[uart_qual_pkg::SC_RX_DONE] ##1 rx_done_flag_o;
  endsequence
  AST_DONE_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    accept |=> s_done_raised)
    else $error("accepted frame did not raise done");
  // With the error view selected, a write must leave the mode bit alone
  AST_MODE_HIGH_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_sc && frame_err_access_sel_reg |=>
    $stable(serial_control_reg[uart_qual_pkg::SC_MODE_HIGH]))
    else $error("mode high bit written while error view selected");
endmodule : uart_rx_qualifier
`default_nettype wire

// file: uart_qual_pkg.sv
// Constants, register map and carrier types for the serial receive qualifier.
// Assumes a classic Wishbone master with 32-bit data and a 25 MHz clock.
package uart_qual_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_RX_DATA     = 8'h08;
  localparam logic [7:0] ADDR_T1_RELOAD   = 8'h0c;
  localparam logic [7:0] ADDR_T3_RELOAD   = 8'h10;
  localparam logic [7:0] ADDR_CLOCK_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_SLAVE_ADDR  = 8'h18;

  // ==========================================================
  // Field positions
  localparam int SC_MODE_HIGH = 7;
  localparam int SC_MODE_LOW  = 6;
  localparam int SC_MP_EN     = 5;
  localparam int SC_RX_EN     = 4;
  localparam int SC_RX_NINTH  = 2;
  localparam int SC_RX_DONE   = 0;
  localparam int PC_BAUD_DBL  = 7;
  localparam int PC_ERR_SEL   = 6;
  localparam int CK_T1_CLKSEL = 4;
  localparam int CK_BAUD_SRC  = 5;

  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] SERIAL_CTRL_RESET = 8'h00;
  localparam int         SYS_CLK_HZ        = 25_000_000;
  localparam int         T1_PRESCALE       = 12;
  localparam int         RX_OVERSAMPLE     = 16;
  localparam logic [3:0] SAMPLE_CENTRE     = 4'h7;

  typedef enum logic [1:0] {
    MODE_SYNC = 2'h0,
    MODE_VAR8 = 2'h1,
    MODE_FIX9 = 2'h2,
    MODE_VAR9 = 2'h3
  } serial_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       stop_ok;
  } rx_frame_t;

endpackage : uart_qual_pkg

// file: uart_baud_gen.sv
// Baud tick generator: one-cycle enable at sixteen times the bit rate.
// Assumes software keeps the reload values within their legal range.
`timescale 1ns/10ps
`default_nettype none
module uart_baud_gen (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Configuration
  input  wire logic [1:0]  mode_i,
  input  wire logic        baud_double_i,
  input  wire logic        timer1_clock_select_i,
  input  wire logic        use_timer3_i,
  input  wire logic [7:0]  timer1_reload_high_i,
  input  wire logic [15:0] timer3_reload_i,
  // Tick out
  output logic             tick_o
);
  logic [3:0]  pre_reg;
  logic [15:0] cnt_reg;
  logic [15:0] reload;
  logic        src_en;
  logic        ovf;
  logic [1:0]  dbl_reg;
  logic        is_fix;

  assign is_fix = (mode_i == 2'h2);
  // Undivided clock when clock select is one
  assign src_en = is_fix | use_timer3_i | timer1_clock_select_i |
                  (pre_reg == 4'(uart_qual_pkg::T1_PRESCALE - 1));
  // Timer 1 in auto-reload: only its high byte matters
  assign reload = is_fix ? 16'hfffe :
                  use_timer3_i ? timer3_reload_i : {8'hff, timer1_reload_high_i};
  assign ovf    = src_en && (cnt_reg == 16'hffff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= 4'h0;
      // Start at the top: the first reload comes at once, not after a full 16-bit wrap
      cnt_reg <= 16'hffff;
      dbl_reg <= 2'h0;
      tick_o  <= 1'b0;
    end else begin
      pre_reg <= src_en ? 4'h0 : pre_reg + 4'h1;
      if (src_en) cnt_reg <= ovf ? reload : cnt_reg + 16'h0001;
      // Doubling skips the extra divide-by-two
      if (ovf) dbl_reg <= dbl_reg + 2'h1;
      tick_o <= ovf && (baud_double_i || dbl_reg[0]);
    end
  end
endmodule : uart_baud_gen
`default_nettype wire

// file: remote_serial_node.sv
// Remote serial node model: drives whole frames onto the receive line.
// Assumes the system clock; one bit lasts BIT_CYC clock cycles.
`timescale 1ns/10ps
`default_nettype none
module remote_serial_node #(
  parameter int BIT_CYC = 64
) (
  // Clock
  input  wire logic clk_i,
  // Serial line
  output logic      txd_o
);
  // ==========================================================
  // Frame driver
  // Line rests high between frames, as a real idle line does
  initial txd_o = 1'b1;

  task automatic send(input logic [7:0] d, input logic nine, input logic b9,
                      input logic stp);
    logic [10:0] bits;
    int          n;
    bits = {stp, b9, d, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) bits[9] = stp;
    for (int i = 0; i < n; i++) begin
      txd_o <= bits[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    txd_o <= 1'b1;
  endtask : send
endmodule : remote_serial_node
`default_nettype wire

// file: tb_uart_frame_error_multiproc.sv
// Testbench for the receive qualifier: Wishbone tasks plus a remote node.
// Assumes timer 1 reload high 8'hfc, undivided, doubled: 64 cycles a bit.
`timescale 1ns/10ps
`default_nettype none
module tb_uart_frame_error_multiproc;
  // Bench clock is not the nominal 16 MHz oscillator, so the 38400 ceiling does not bind
  localparam int         BIT_CYC = 64;
  localparam logic [7:0] SC = uart_qual_pkg::ADDR_SERIAL_CTRL;
  localparam logic [7:0] PC = uart_qual_pkg::ADDR_POWER_CTRL;
  localparam logic [7:0] RX = uart_qual_pkg::ADDR_RX_DATA;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        rxd;
  logic        done;
  logic [31:0] q;
  int          num_errors = 0;
  int          checked = 0;

  always #20 clk_i = ~clk_i;

  uart_rx_qualifier i_uart_rx_qualifier (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rxd_i(rxd), .rx_done_flag_o(done)
  );
  remote_serial_node #(.BIT_CYC(BIT_CYC)) i_remote_serial_node (
    .clk_i(clk_i), .txd_o(rxd)
  );

  // ==========================================================
  // Closing report
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================
  // Bus cycles
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int   n;
    logic ok;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    ok = (ack_o === 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
    if (!ok) begin
      num_errors++;
      end_sim();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd

  // Idle gap after each frame so the next start edge is a clean fall
  task automatic fr(input logic [7:0] d, input logic nine, input logic b9,
                    input logic stp);
    i_remote_serial_node.send(d, nine, b9, stp);
    repeat (BIT_CYC) @(posedge clk_i);
  endtask : fr

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(SC, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    wr(uart_qual_pkg::ADDR_CLOCK_CTRL, 32'h10);
    wr(uart_qual_pkg::ADDR_T1_RELOAD, 32'hfc);
    wr(PC, 32'h80);
    wr(SC, 32'h50);
    // Reload counter may still run the slow reset period; let it reach the new one
    repeat (5 * BIT_CYC) @(posedge clk_i);
    fr(8'ha5, 1'b0, 1'b0, 1'b1);
    rd(RX, 32'ha5);
    rd(SC, 32'h55);
    chk({31'h0, done}, 32'h1);
    wr(SC, 32'h50);
    fr(8'h3c, 1'b0, 1'b0, 1'b0);
    rd(SC, 32'h51);
    wr(PC, 32'hc0);
    rd(SC, 32'hd1);
    wr(SC, 32'hd0);
    fr(8'h11, 1'b0, 1'b0, 1'b1);
    rd(SC, 32'hd5);
    // Clear the error but keep done set, so the next bad frame is dropped
    wr(SC, 32'h51);
    rd(SC, 32'h51);
    wr(PC, 32'h80);
    rd(SC, 32'h51);
    fr(8'h22, 1'b0, 1'b0, 1'b0);
    rd(RX, 32'h11);
    wr(PC, 32'hc0);
    rd(SC, 32'hd1);
    wr(SC, 32'h50);
    wr(PC, 32'h80);
    wr(SC, 32'h70);
    fr(8'h44, 1'b0, 1'b0, 1'b0);
    rd(SC, 32'h70);
    chk({31'h0, done}, 32'h0);
    fr(8'h45, 1'b0, 1'b0, 1'b1);
    rd(SC, 32'h75);
    rd(RX, 32'h45);
    wr(PC, 32'hc0);
    wr(SC, 32'h50);
    wr(PC, 32'h80);
    wr(uart_qual_pkg::ADDR_SLAVE_ADDR, 32'h0000ff5a);
    wr(SC, 32'hf0);
    fr(8'h33, 1'b1, 1'b1, 1'b1);
    rd(SC, 32'hf0);
    fr(8'h77, 1'b1, 1'b0, 1'b1);
    rd(SC, 32'hf0);
    fr(8'h5a, 1'b1, 1'b1, 1'b1);
    rd(SC, 32'hf5);
    rd(RX, 32'h5a);
    wr(SC, 32'hd0);
    fr(8'h3c, 1'b1, 1'b0, 1'b1);
    rd(SC, 32'hd1);
    rd(RX, 32'h3c);
    wr(SC, 32'hf0);
    fr(8'h66, 1'b1, 1'b1, 1'b0);
    wr(PC, 32'hc0);
    rd(SC, 32'hf0);
    wr(SC, 32'h70);
    rd(SC, 32'h70);
    wr(PC, 32'h80);
    rd(SC, 32'hf0);
    wr(SC, 32'h30);
    fr(8'h12, 1'b0, 1'b0, 1'b0);
    wr(PC, 32'hc0);
    rd(SC, 32'h30);
    chk({31'h0, done}, 32'h0);
    // Timer 3 as the bit-rate source, reload taken as one 16-bit value
    wr(PC, 32'h80);
    wr(uart_qual_pkg::ADDR_T3_RELOAD, 32'h0000fffc);
    wr(uart_qual_pkg::ADDR_CLOCK_CTRL, 32'h30);
    wr(SC, 32'h50);
    fr(8'hc3, 1'b0, 1'b0, 1'b1);
    rd(SC, 32'h55);
    rd(RX, 32'hc3);
    // Fixed-rate nine-bit mode, undoubled: also 64 cycles a bit
    wr(PC, 32'h0);
    wr(SC, 32'h90);
    fr(8'h69, 1'b1, 1'b1, 1'b1);
    rd(SC, 32'h95);
    rd(RX, 32'h69);
    chk({31'h0, done}, 32'h1);
    end_sim();
  end
endmodule : tb_uart_frame_error_multiproc
`default_nettype wire
